// [logic/ds3_test_pkg.sv]
// constants, types and field layouts for the ds3 test and loopback control block
// assumes a single 200 MHz clock and plain-port control from a craft processor
// Notes on behaviour
// [RL1] inband loopback code detection can be enabled or disabled; disabled ignores codes
// [RL2] customer loss of signal sends chosen keep-alive to network: idle, AIS, none
// [RL3] timeout disabled, 20, 60, 120 min or 24 h; expiry releases any test
// [RL4] loopback select button during loopback releases it to normal
// [RL5] pattern and loopback never active together
// [RL6] patterns can go toward network and customer at once
// [RL7] error counter counts bit errors, holds at 65535
// [RL8] loss of pattern sync forces count to 65535
// [RL9] reset-errors command clears counter to zero
// [RL10] pattern to network sends unframed all ones to customer
// [RL11] pattern types: 2^23-1, QRSS, blue, idle, user defined
// [RL12] user pattern defaults to eight zeros then eight ones
// [RL13] pattern to customer sends framed idle to network
// [RL14] one framing for both directions: C-bit, M13 or unframed
// [RL15] pattern clock is recovered network clock or local reference
// [RL16] network clock is the default timing source
// [RL17] factory reset restores timeout, inband enable and keep-alive choice
// [RL18] far end arms with 1011100 for 5 s, then 20 s to identify
// [RL19] deactivation code 1110110 releases inband loopback or pattern at once
// [RL20] QRSS is 2^20-1 sequence with zero runs limited
// [RL21] 16-bit error counter, cleared when a new pattern test starts
// [RL22] timer starts with a test, stops silently on manual end
package ds3_test_pkg;

  // timing source and timeouts
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned MIN_20        = 20;
  localparam int unsigned MIN_60        = 60;
  localparam int unsigned MIN_120       = 120;
  localparam int unsigned MIN_1440      = 1440;
  localparam int unsigned SEC_PER_MIN   = 60;
  localparam int unsigned TICK_CYCLES   = CLK_HZ;          // one second tick
  localparam int unsigned ARM_SEC       = 5;
  localparam int unsigned ID_WINDOW_SEC = 20;

  // inband codes and test identifiers
  localparam logic [6:0]  ARM_CODE      = 7'h5C;           // 1011100
  localparam logic [6:0]  DEACT_CODE    = 7'h76;           // 1110110
  localparam logic [15:0] ID_LOOPBACK   = 16'hD3D3;
  localparam logic [15:0] ID_PRBS23     = 16'h2E23;
  localparam logic [15:0] ID_QRSS       = 16'h2E20;
  localparam logic [15:0] ID_BLUE       = 16'hD741;
  localparam logic [15:0] ID_IDLE       = 16'hD742;
  localparam logic [15:0] ID_USER       = 16'hD743;

  // pattern constants
  localparam logic [15:0] USER_DEFAULT  = 16'h00FF;        // sent msb first
  localparam logic [15:0] ERR_MAX       = 16'hFFFF;
  localparam logic [22:0] PRBS23_SEED   = 23'h7FFFFF;
  localparam logic [19:0] QRSS_SEED     = 20'hFFFFF;
  localparam logic [4:0]  QRSS_ZMAX     = 5'h0E;           // longest zero run kept
  localparam logic [3:0]  IDLE_NIB      = 4'hC;            // 1100 repeating

  typedef enum logic [2:0] {TO_OFF, TO_20, TO_60, TO_120, TO_24H} timeout_t;
  typedef enum logic [1:0] {KA_IDLE, KA_AIS, KA_NONE} keep_alive_choice_t;
  typedef enum logic [2:0] {PT_PRBS23, PT_QRSS, PT_BLUE, PT_IDLE, PT_USER} pattern_t;
  typedef enum logic [1:0] {FR_CBIT, FR_M13, FR_NONE} framing_t;
  typedef enum logic [2:0] {TX_PASS, TX_PATTERN, TX_ONES, TX_IDLE, TX_AIS, TX_OFF} tx_src_t;

  localparam timeout_t           TIMEOUT_DEFAULT = TO_120;
  localparam keep_alive_choice_t KA_DEFAULT      = KA_AIS;
  localparam logic               INBAND_DEFAULT  = 1'b1;

  // what each line transmitter shows
  typedef struct packed {
    tx_src_t  src;
    framing_t framing;   // no_framing for ones, C-bit etc otherwise
  } tx_sel_t;

  // craft commands, one-cycle pulses
  typedef struct packed {
    logic start_network_side_clock_pattern;
    logic start_cust_pattern;
    logic start_loopback;
    logic stop_test;
    logic reset_errors;
    logic factory_reset;
  } cmd_t;

endpackage

// [logic/ds3_test_ctrl.sv]
// test pattern, loopback and timeout control for a ds3 interface
// assumes framers/line codecs outside; link clocks and pins arrive asynchronous
module ds3_test_ctrl
  import ds3_test_pkg::*;
#(
  parameter int unsigned TICK = TICK_CYCLES   // cycles per second, shorten in sim
) (
  // clock and reset
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  // craft commands and provisioning
  input  wire cmd_t               cmd_i,
  input  wire timeout_t           timeout_sel_i,
  input  wire logic               set_timeout_i,
  input  wire logic               inband_en_i,
  input  wire logic               set_inband_i,
  input  wire keep_alive_choice_t keep_alive_choice_i,
  input  wire logic               set_keep_alive_i,
  input  wire pattern_t           pattern_sel_i,
  input  wire framing_t           framing_sel_i,
  input  wire logic               local_timing_i,
  input  wire logic [15:0]        user_pattern_i,
  input  wire logic               set_user_pattern_i,
  // pins from outside the clock domain
  input  wire logic               loopback_select_button_i,
  input  wire logic               loss_of_signal_i,
  input  wire logic               network_side_clock_i,
  input  wire logic               local_ref_clock_i,
  input  wire logic               rx_data_i,
  input  wire logic               inband_valid_i,
  input  wire logic [15:0]        inband_code_i,
  // status and line control
  output logic                    loopback_o,
  output logic                    network_side_clock_pattern_o,
  output logic                    cust_pattern_o,
  output logic [15:0]             pattern_errors_o,
  output logic                    pattern_bit_o,
  output logic                    pattern_strobe_o,
  output tx_sel_t                 network_side_clock_tx_o,
  output tx_sel_t                 cust_tx_o,
  output logic                    inband_en_o,
  output timeout_t                timeout_o,
  output keep_alive_choice_t      keep_alive_o
);

  localparam int unsigned NSYNC = 6;

  typedef enum logic [1:0] {IB_IDLE, IB_ARMING, IB_WAIT_ID} ib_state_t;

  typedef struct packed {
    logic [NSYNC-1:0]   s1, s2;
    logic               clk_prev;
    logic               btn_prev;
    logic [15:0]        code_s1;
    logic [15:0]        code_q;
    timeout_t           timeout;
    logic               inband_en;
    keep_alive_choice_t ka;
    logic [15:0]        user_pat;
    logic               lbk, pat_n, pat_c, inband_test;
    pattern_t           pat;
    framing_t           fr;
    logic [31:0]        sec_cnt;
    logic [10:0]        min_cnt;   // elapsed minutes since test start
    logic [5:0]         sec_in_min;
    ib_state_t          ib;
    logic [4:0]         ib_sec;
    logic [22:0]        prbs23;
    logic [19:0]        qrss;
    logic [4:0]         zrun;
    logic [3:0]         idx;
    logic               bit_q, strobe, prev_bit;
    logic [15:0]        errs;
    logic [3:0]         good_run;
    logic [3:0]         bad_run;
    logic               in_sync;
  } state_t;

  state_t r, next_r;
  logic [NSYNC-1:0] async_in;
  logic btn_s, los_s, nclk_s, lclk_s, rx_s, ib_v_s;
  logic clk_sel, edge_en, btn_press, any_test, expire, ib_ok;
  logic gen_bit, next23, next20, qbit;
  logic [10:0] limit;

  assign async_in = {loopback_select_button_i, loss_of_signal_i, network_side_clock_i,
                     local_ref_clock_i, rx_data_i, inband_valid_i};
  assign {btn_s, los_s, nclk_s, lclk_s, rx_s, ib_v_s} = r.s2;

  // timeout selection in minutes
  always_comb begin
    case (r.timeout)
      TO_20:   limit = 11'(MIN_20);
      TO_60:   limit = 11'(MIN_60);
      TO_120:  limit = 11'(MIN_120);
      TO_24H:  limit = 11'(MIN_1440);
      default: limit = 11'h000;
    endcase
  end

  // [RL15] clock source select
  assign clk_sel   = local_timing_i ? lclk_s : nclk_s;
  assign edge_en   = clk_sel & ~r.clk_prev;
  assign btn_press = btn_s & ~r.btn_prev;
  assign any_test  = r.lbk | r.pat_n | r.pat_c;
  // [RL3] expiry releases test
  assign expire    = any_test && (r.timeout != TO_OFF) && (r.min_cnt >= limit);
  // [RL1] codes ignored when disabled
  assign ib_ok     = ib_v_s & r.inband_en;
  assign next23    = r.prbs23[22] ^ r.prbs23[17];
  assign next20    = r.qrss[19] ^ r.qrss[16];
  // [RL20] qrss forces a one after a long zero run
  assign qbit      = (r.zrun >= QRSS_ZMAX) ? 1'b1 : r.qrss[19];

  // [RL11] pattern bit per type
  always_comb begin
    case (r.pat)
      PT_PRBS23: gen_bit = r.prbs23[22];
      PT_QRSS:   gen_bit = qbit;
      PT_BLUE:   gen_bit = 1'b1;
      PT_IDLE:   gen_bit = IDLE_NIB[3 - r.idx[1:0]];
      PT_USER:   gen_bit = r.user_pat[4'hF - r.idx];
      default:   gen_bit = 1'b0;
    endcase
  end

  // all next-state logic
  always_comb begin
    next_r          = r;
    next_r.s1       = async_in;
    next_r.s2       = r.s1;
    next_r.clk_prev = clk_sel;
    next_r.btn_prev = btn_s;
    next_r.strobe   = 1'b0;
    // code delayed two stages so it still stands while the synced valid does
    next_r.code_s1  = inband_code_i;
    next_r.code_q   = r.code_s1;
    // provisioning writes
    if (set_timeout_i) next_r.timeout = timeout_sel_i;
    if (set_inband_i) next_r.inband_en = inband_en_i;
    if (set_keep_alive_i) next_r.ka = keep_alive_choice_i;
    if (set_user_pattern_i) next_r.user_pat = user_pattern_i;
    // [RL17] factory defaults
    if (cmd_i.factory_reset) begin
      next_r.timeout   = TIMEOUT_DEFAULT;
      next_r.inband_en = INBAND_DEFAULT;
      next_r.ka        = KA_DEFAULT;
    end
    // one-second timebase for timeout and inband timers
    if (r.sec_cnt >= 32'(TICK - 1)) begin
      next_r.sec_cnt = 32'h0000_0000;
      if (r.ib != IB_IDLE) next_r.ib_sec = r.ib_sec + 5'h01;
      if (any_test) begin
        next_r.sec_in_min = (r.sec_in_min == 6'(SEC_PER_MIN - 1)) ? 6'h00 : r.sec_in_min + 6'h01;
        if (r.sec_in_min == 6'(SEC_PER_MIN - 1)) next_r.min_cnt = r.min_cnt + 11'h001;
      end
    end else begin
      next_r.sec_cnt = r.sec_cnt + 32'h0000_0001;
    end
    // [RL18] arming then identifier window
    case (r.ib)
      IB_IDLE: begin
        if (ib_ok && r.code_q[6:0] == ARM_CODE) begin
          next_r.ib = IB_ARMING;
          next_r.ib_sec = 5'h00;
        end
      end
      IB_ARMING: begin
        if (!(ib_ok && r.code_q[6:0] == ARM_CODE)) next_r.ib = IB_IDLE;
        else if (r.ib_sec >= 5'(ARM_SEC)) begin
          next_r.ib = IB_WAIT_ID;
          next_r.ib_sec = 5'h00;
        end
      end
      IB_WAIT_ID: begin
        if (r.ib_sec >= 5'(ID_WINDOW_SEC)) next_r.ib = IB_IDLE;
      end
      default: next_r.ib = IB_IDLE;
    endcase
    // manual and inband test control; each start also restarts timer
    if (cmd_i.start_loopback || (r.ib == IB_WAIT_ID && ib_ok && r.code_q == ID_LOOPBACK)) begin
      // [RL5] loopback displaces patterns
      next_r.lbk = 1'b1;
      next_r.pat_n = 1'b0;
      next_r.pat_c = 1'b0;
      next_r.inband_test = !cmd_i.start_loopback;
      next_r.ib = IB_IDLE;
      // [RL22] timer starts with test
      next_r.min_cnt = 11'h000;
      next_r.sec_in_min = 6'h00;
    end else if (cmd_i.start_network_side_clock_pattern || cmd_i.start_cust_pattern ||
                 (r.ib == IB_WAIT_ID && ib_ok && (r.code_q == ID_PRBS23 ||
                  r.code_q == ID_QRSS || r.code_q == ID_BLUE ||
                  r.code_q == ID_IDLE || r.code_q == ID_USER))) begin
      next_r.lbk = 1'b0;
      // [RL6] both directions may run
      if (r.ib == IB_WAIT_ID && !cmd_i.start_network_side_clock_pattern && !cmd_i.start_cust_pattern) begin
        next_r.pat_n = 1'b1;
        next_r.pat_c = 1'b1;
        next_r.inband_test = 1'b1;
        next_r.ib = IB_IDLE;
        case (r.code_q)
          ID_PRBS23: next_r.pat = PT_PRBS23;
          ID_QRSS:   next_r.pat = PT_QRSS;
          ID_BLUE:   next_r.pat = PT_BLUE;
          ID_IDLE:   next_r.pat = PT_IDLE;
          default:   next_r.pat = PT_USER;
        endcase
      end else begin
        next_r.pat_n = r.pat_n | cmd_i.start_network_side_clock_pattern;
        next_r.pat_c = r.pat_c | cmd_i.start_cust_pattern;
        next_r.inband_test = 1'b0;
        next_r.pat = pattern_sel_i;
      end
      // [RL14] one framing for both directions
      next_r.fr = framing_sel_i;
      // [RL21] fresh count on new test
      next_r.errs = 16'h0000;
      next_r.in_sync = 1'b0;
      next_r.good_run = 4'h0;
      next_r.bad_run = 4'h0;
      next_r.prbs23 = PRBS23_SEED;
      next_r.qrss = QRSS_SEED;
      next_r.idx = 4'h0;
      next_r.zrun = 5'h00;
      next_r.min_cnt = 11'h000;
      next_r.sec_in_min = 6'h00;
    end else if (cmd_i.stop_test || (btn_press && r.lbk) ||
                 (ib_ok && r.inband_test && r.code_q[6:0] == DEACT_CODE) || expire) begin
      // [RL4] button releases loopback
      // [RL19] deactivation releases at once
      next_r.lbk = 1'b0;
      next_r.pat_n = 1'b0;
      next_r.pat_c = 1'b0;
      next_r.inband_test = 1'b0;
      next_r.min_cnt = 11'h000;
      next_r.sec_in_min = 6'h00;
    end
    // generator and checker advance on the chosen link clock edge
    if (edge_en && (r.pat_n || r.pat_c)) begin
      next_r.bit_q = gen_bit;
      next_r.strobe = 1'b1;
      next_r.idx = r.idx + 4'h1;
      next_r.prbs23 = {r.prbs23[21:0], next23};
      next_r.qrss = {r.qrss[18:0], next20};
      next_r.zrun = (qbit == 1'b0) ? r.zrun + 5'h01 : 5'h00;
      // loopback-side receive compared to the sent bit two edges later
      next_r.prev_bit = r.bit_q;
      if (rx_s == r.prev_bit) begin
        next_r.bad_run = 4'h0;
        if (r.good_run != 4'hF) next_r.good_run = r.good_run + 4'h1;
        if (r.good_run == 4'hE) next_r.in_sync = 1'b1;
      end else begin
        next_r.good_run = 4'h0;
        if (r.bad_run != 4'hF) next_r.bad_run = r.bad_run + 4'h1;
        // [RL7] saturating error count
        if (r.in_sync && r.errs != ERR_MAX) next_r.errs = r.errs + 16'h0001;
      end
    end
    // [RL8] sync loss forces full count
    // eighth errored bit in a row means sync lost; isolated errors only count up
    if ((r.pat_n || r.pat_c) && r.in_sync && edge_en && rx_s != r.prev_bit &&
        r.bad_run == 4'h7) begin
      next_r.in_sync = 1'b0;
      next_r.errs = ERR_MAX;
    end
    if ((r.pat_n || r.pat_c) && !r.in_sync && r.strobe && r.idx == 4'h0 && r.errs != 16'h0000)
      next_r.errs = ERR_MAX;
    // [RL9] clear on command
    if (cmd_i.reset_errors) next_r.errs = 16'h0000;
  end

  // single register for all state
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      r           <= '0;
      r.timeout   <= TIMEOUT_DEFAULT;
      r.inband_en <= INBAND_DEFAULT;
      r.ka        <= KA_DEFAULT;
      // [RL12] default user pattern
      r.user_pat  <= USER_DEFAULT;
      r.prbs23    <= PRBS23_SEED;
      r.qrss      <= QRSS_SEED;
      r.ib        <= IB_IDLE;
      r.pat       <= PT_PRBS23;
      r.fr        <= FR_CBIT;
    end else begin
      r <= next_r;
    end
  end

  // line transmit selection
  always_comb begin
    network_side_clock_tx_o = '{src: TX_PASS, framing: r.fr};
    cust_tx_o = '{src: TX_PASS, framing: r.fr};
    if (r.pat_n) network_side_clock_tx_o.src = TX_PATTERN;
    // [RL13] framed idle toward network
    else if (r.pat_c) network_side_clock_tx_o = '{src: TX_IDLE, framing: (r.fr == FR_NONE) ? FR_CBIT : r.fr};
    // [RL2] keep-alive on customer loss
    else if (los_s && !r.lbk)
      network_side_clock_tx_o.src = (r.ka == KA_IDLE) ? TX_IDLE : (r.ka == KA_AIS) ? TX_AIS : TX_OFF;
    if (r.pat_c) cust_tx_o.src = TX_PATTERN;
    // [RL10] unframed ones toward customer
    else if (r.pat_n) cust_tx_o = '{src: TX_ONES, framing: FR_NONE};
  end

  // [RL16] local_timing_i low selects network clock
  assign loopback_o       = r.lbk;
  assign network_side_clock_pattern_o   = r.pat_n;
  assign cust_pattern_o   = r.pat_c;
  assign pattern_errors_o = r.errs;
  assign pattern_bit_o    = r.bit_q;
  assign pattern_strobe_o = r.strobe;
  assign inband_en_o      = r.inband_en;
  assign timeout_o        = r.timeout;
  assign keep_alive_o     = r.ka;

endmodule // ds3_test_ctrl

// [testbench/ds3_test_ctrl_chk.sv]
// concurrent checks on the ds3 test and loopback control ports
// assumes one clock domain with a synchronous active-low reset
module ds3_test_ctrl_chk
  import ds3_test_pkg::*;
(
  // clock and reset
  input wire logic               mclk_i,
  input wire logic               rst_n_i,
  // commands and provisioning writes
  input wire cmd_t               cmd_i,
  input wire logic               set_timeout_i,
  input wire logic               set_inband_i,
  input wire logic               set_keep_alive_i,
  // status seen
  input wire logic               loopback_o,
  input wire logic               network_side_clock_pattern_o,
  input wire logic               cust_pattern_o,
  input wire logic [15:0]        pattern_errors_o,
  input wire logic               pattern_strobe_o,
  input wire tx_sel_t            network_side_clock_tx_o,
  input wire tx_sel_t            cust_tx_o,
  input wire logic               inband_en_o,
  input wire timeout_t           timeout_o,
  input wire keep_alive_choice_t keep_alive_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // saturated count with nothing asked to clear it
  sequence s_sat_quiet;
    pattern_errors_o == 16'hFFFF && !cmd_i.reset_errors && !cmd_i.start_network_side_clock_pattern
      && !cmd_i.start_cust_pattern;
  endsequence
  // all three provisioned values back at their defaults
  sequence s_dflt;
    timeout_o == TIMEOUT_DEFAULT && inband_en_o == INBAND_DEFAULT && keep_alive_o == KA_DEFAULT;
  endsequence
  a_tests_exclusive: assert property (!(loopback_o && (network_side_clock_pattern_o || cust_pattern_o)))
    else $error("loopback and pattern active together");
  a_network_side_clock_ones: assert property (network_side_clock_pattern_o && !cust_pattern_o |->
    cust_tx_o == {TX_ONES, FR_NONE})
    else $error("customer side not unframed ones");
  a_cust_idle: assert property (cust_pattern_o && !network_side_clock_pattern_o |->
    network_side_clock_tx_o.src == TX_IDLE && network_side_clock_tx_o.framing != FR_NONE)
    else $error("network side not framed idle");
  a_err_hold: assert property (s_sat_quiet |=> pattern_errors_o == 16'hFFFF)
    else $error("error count left saturation");
  a_err_clear: assert property (cmd_i.reset_errors |=> pattern_errors_o == 16'h0000)
    else $error("error count not cleared");
  a_start_fresh: assert property (cmd_i.start_network_side_clock_pattern && !cmd_i.start_loopback
    && !loopback_o |=> network_side_clock_pattern_o && pattern_errors_o == 16'h0000)
    else $error("pattern start not fresh");
  a_lb_wins: assert property (cmd_i.start_loopback |=>
    loopback_o && !network_side_clock_pattern_o && !cust_pattern_o)
    else $error("loopback start not exclusive");
  a_stop_all: assert property (cmd_i.stop_test && !cmd_i.start_loopback &&
    !cmd_i.start_network_side_clock_pattern && !cmd_i.start_cust_pattern |=>
    !loopback_o && !network_side_clock_pattern_o && !cust_pattern_o)
    else $error("manual stop left a test active");
  a_factory_dflt: assert property (cmd_i.factory_reset && !set_timeout_i && !set_inband_i
    && !set_keep_alive_i |=> s_dflt)
    else $error("factory defaults not restored");
  a_strobe_pulse: assert property (pattern_strobe_o |=> !pattern_strobe_o)
    else $error("pattern strobe longer than a cycle");
endmodule // ds3_test_ctrl_chk

bind ds3_test_ctrl ds3_test_ctrl_chk chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i),
  .set_timeout_i(set_timeout_i), .set_inband_i(set_inband_i),
  .set_keep_alive_i(set_keep_alive_i), .loopback_o(loopback_o),
  .network_side_clock_pattern_o(network_side_clock_pattern_o), .cust_pattern_o(cust_pattern_o),
  .pattern_errors_o(pattern_errors_o), .pattern_strobe_o(pattern_strobe_o),
  .network_side_clock_tx_o(network_side_clock_tx_o), .cust_tx_o(cust_tx_o), .inband_en_o(inband_en_o),
  .timeout_o(timeout_o), .keep_alive_o(keep_alive_o));

// [testbench/ds3_line_partner.sv]
// far-end line model: free recovered clock, looped pattern, inband codes
// assumes the bench calls send_code from a falling clock edge
module ds3_line_partner;
  timeunit 1ns;
  timeprecision 100ps;
  logic        net_clk = 1'b0;
  logic        rx_data = 1'b0;
  logic        bad = 1'b0;
  logic        held = 1'b0;
  logic        code_valid = 1'b0;
  logic [15:0] code = 16'hFFFF;
  wire logic   pattern_bit;
  // recovered ds3 clock runs free at 80 ns
  always #40 net_clk = ~net_clk;
  // far end loops the pattern back one bit late, inverted when corruption is asked for
  always @(negedge net_clk) begin
    held    <= pattern_bit;
    rx_data <= held ^ bad;
  end
  task automatic send_code(input logic [15:0] c, input int ns);
    code = c;
    code_valid = 1'b1;
    #(ns);
    code_valid = 1'b0;
    code = ~c; // released line shows no stale code
    #10; // valid stays low two clocks between codes
  endtask
endmodule // ds3_line_partner

// [testbench/test_ds3_test_ctrl.sv]
// self-checking bench for the ds3 test and loopback control block
// assumes a shortened second of TK cycles and the far-end line model
module test_ds3_test_ctrl;
  import ds3_test_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned TK = 20;
  localparam cmd_t C_NP = 6'h20, C_CP = 6'h10, C_LB = 6'h08, C_ST = 6'h04, C_RE = 6'h02;
  logic               mclk = 1'b0, rst_n = 1'b0, set_to = 1'b0, set_ib = 1'b0, ib_en = 1'b1;
  logic               set_ka = 1'b0, loc = 1'b0, btn = 1'b0, lref = 1'b0, loss_of_signal = 1'b0;
  cmd_t               cmd = '0;
  timeout_t           to_sel = TO_120;
  keep_alive_choice_t ka_sel = KA_AIS;
  pattern_t           pat = PT_PRBS23;
  framing_t           frm = FR_CBIT;
  logic               lb, np, cp, pstb, ib_o;
  logic [15:0]        errs, r;
  logic [31:0]        w;
  tx_sel_t            ntx, ctx;
  timeout_t           to_o;
  keep_alive_choice_t ka_o;
  int                 n_errors = 0, samples_checked = 0, n;
  ds3_line_partner far ();
  ds3_test_ctrl #(.TICK(TK)) dut (.mclk_i(mclk), .rst_n_i(rst_n), .cmd_i(cmd),
    .timeout_sel_i(to_sel), .set_timeout_i(set_to), .inband_en_i(ib_en), .set_inband_i(set_ib),
    .keep_alive_choice_i(ka_sel), .set_keep_alive_i(set_ka), .pattern_sel_i(pat),
    .framing_sel_i(frm), .local_timing_i(loc), .user_pattern_i(16'h0F0F),
    .set_user_pattern_i(1'b0), .loopback_select_button_i(btn), .loss_of_signal_i(loss_of_signal),
    .network_side_clock_i(far.net_clk), .local_ref_clock_i(lref), .rx_data_i(far.rx_data),
    .inband_valid_i(far.code_valid), .inband_code_i(far.code), .loopback_o(lb),
    .network_side_clock_pattern_o(np), .cust_pattern_o(cp), .pattern_errors_o(errs),
    .pattern_bit_o(far.pattern_bit), .pattern_strobe_o(pstb), .network_side_clock_tx_o(ntx),
    .cust_tx_o(ctx), .inband_en_o(ib_o), .timeout_o(to_o), .keep_alive_o(ka_o));
  // main clock 200 MHz, local reference slower so the two sources differ
  always #2.5 mclk = ~mclk;
  always #50 lref = ~lref;
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cy(input int k);
    repeat (k) @(negedge mclk);
  endtask
  // one-cycle command; returns one edge after it was taken
  task automatic go(input cmd_t c);
    @(negedge mclk);
    cmd = c;
    @(negedge mclk);
    cmd = '0;
  endtask
  task automatic prov(input timeout_t t, input keep_alive_choice_t k, input logic e);
    @(negedge mclk);
    to_sel = t;
    ka_sel = k;
    ib_en = e;
    {set_to, set_ka, set_ib} = 3'b111;
    @(negedge mclk);
    {set_to, set_ka, set_ib} = 3'b000;
    cy(2);
  endtask
  task automatic strobes(input logic l);
    loc = l;
    go(C_NP);
    cy(20);
    n = 0;
    repeat (1600) begin
      @(negedge mclk);
      n += int'(pstb === 1'b1);
    end
    go(C_ST);
  endtask
  task automatic end_of_test();
    $display("samples_checked %0d n_errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog well beyond the expected run of about 60k cycles
  initial begin
    #450_000;
    n_errors++;
    end_of_test();
  end
  initial begin
    timeout_t           tt[2] = '{TO_20, TO_OFF};
    keep_alive_choice_t keep_alive_choice[3] = '{KA_IDLE, KA_AIS, KA_NONE};
    tx_src_t            kx[3] = '{TX_IDLE, TX_AIS, TX_OFF};
    pattern_t           pts[5] = '{PT_PRBS23, PT_QRSS, PT_BLUE, PT_IDLE, PT_USER};
    framing_t           fms[5] = '{FR_CBIT, FR_M13, FR_NONE, FR_CBIT, FR_M13};
    cy(16);
    rst_n = 1'b1;
    cy(2);
    chk("timeout", TO_120, to_o);
    chk("inband", 1, ib_o);
    chk("keep alive", KA_AIS, ka_o);
    prov(TO_20, KA_NONE, 1'b0);
    go(6'h01);
    chk("factory", {TIMEOUT_DEFAULT, KA_DEFAULT, INBAND_DEFAULT}, {to_o, ka_o, ib_o});
    strobes(1'b0);
    chk("network timing", 1, n >= 99 && n <= 101);
    strobes(1'b1);
    chk("local timing", 1, n >= 79 && n <= 81);
    loc = 1'b0;
    foreach (keep_alive_choice[i]) begin
      prov(TIMEOUT_DEFAULT, keep_alive_choice[i], 1'b1);
      loss_of_signal = 1'b1;
      cy(10);
      chk("keep alive tx", kx[i], ntx.src);
      loss_of_signal = 1'b0;
      cy(10);
    end
    foreach (pts[i]) begin
      pat = pts[i];
      frm = fms[i];
      go(C_NP);
      chk("pattern to network", {1'b1, TX_PATTERN, fms[i]}, {np, ntx});
      go(C_ST);
    end
    go(C_NP);
    w = '0;
    for (int i = 0; i < 32; i++) begin
      for (int k = 0; k < 40 && pstb !== 1'b1; k++) @(negedge mclk);
      w = {w[30:0], far.pattern_bit};
      @(negedge mclk);
    end
    n = 0;
    for (int k = 0; k < 16; k++) begin
      r = (16'h00FF << k) | (16'h00FF >> (16 - k));
      n += int'(r === w[15:0] && w[31:16] === w[15:0]);
    end
    chk("user pattern", 1, n);
    chk("customer ones", {TX_ONES, FR_NONE}, ctx);
    go(C_CP);
    chk("both directions", 3, {np, cp});
    chk("customer pattern", TX_PATTERN, ctx.src);
    go(C_ST);
    go(C_CP);
    chk("network idle", TX_IDLE, ntx.src);
    go(C_ST);
    pat = PT_PRBS23;
    go(C_NP);
    cy(3000);
    far.bad = 1'b1;
    cy(3000);
    chk("sync loss count", 16'hFFFF, errs);
    cy(400);
    chk("held count", 16'hFFFF, errs);
    go(C_RE);
    chk("cleared count", 16'h0000, errs);
    far.bad = 1'b0;
    go(C_LB);
    chk("loopback over pattern", 2, {lb, np});
    btn = 1'b1;
    cy(10);
    btn = 1'b0;
    cy(6);
    chk("button release", 0, lb);
    for (int e = 1; e >= 0; e--) begin
      prov(TIMEOUT_DEFAULT, KA_AIS, e[0]);
      far.send_code({9'h000, ARM_CODE}, 6 * TK * 5);
      far.send_code(ID_LOOPBACK, 200);
      cy(10);
      chk("inband loopback", e, lb);
      far.send_code({9'h000, DEACT_CODE}, 200);
      cy(10);
      chk("inband release", 0, lb);
    end
    foreach (tt[i]) begin
      prov(tt[i], KA_AIS, 1'b1);
      go(C_LB);
      cy(22700);
      chk("loopback held", 1, lb);
      cy(1600);
      chk("loopback timeout", tt[i] == TO_OFF, lb);
      go(C_ST);
    end
    end_of_test();
  end
endmodule // test_ds3_test_ctrl
